// >>> rtl/temp_flag_monitor.sv
// Temperature protection flag monitor with an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "temp_flag_params.svh"

module temp_flag_monitor (
  // Clock and reset.
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Measurement samples from the front end, same clock domain.
  input  wire temp_flag_pkg::sample_s    sample,
  // Status flag outputs and the termination voltage level.
  output logic                           charge_overtemp_flag,
  output logic                           discharge_overtemp_flag,
  output logic                           charge_inhibit_flag,
  output logic                           charge_suspend_flag,
  output logic [15:0]                    term_voltage_level,
  // AXI4-Lite write address and data.
  input  wire logic [11:0]               s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [11:0]               s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);

  temp_flag_pkg::state_s q, d;

  // Merges a write word into a 32-bit old value under byte enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Next value of a delay timer; returns the count and whether it expired.
  function automatic logic [8:0] timer_step(input logic cond, input logic [7:0] cnt,
                                            input logic [7:0] dly);
    logic [7:0] n;
    logic       fire;
    n    = 8'h00;
    fire = 1'b0;
    if (cond && dly != 8'h00) begin
      n = cnt + 8'h01;
      if (n >= dly) begin
        fire = 1'b1;
        n    = dly;
      end
    end
    return {fire, n};
  endfunction

  // Decodes a read address into register contents.
  function automatic logic [32:0] read_reg(input temp_flag_pkg::state_s s,
                                           input logic [11:0] a);
    logic [31:0] v;
    logic        ok;
    v  = 32'h0000_0000;
    ok = 1'b1;
    case (a)
      `OFS_CTRL:     v = {16'h0000, s.cfg.taper_volt};
      `OFS_STATUS: begin
        v[`ST_CHG_OT]      = s.flags.chg_ot;
        v[`ST_DSG_OT]      = s.flags.dsg_ot;
        v[`ST_INHIBIT]     = s.flags.inhibit;
        v[`ST_SUSPEND]     = s.flags.suspend;
        v[`ST_CHARGING]    = s.charging;
        v[`ST_DISCHARGING] = s.discharging;
      end
      `OFS_CHG_OT:   v = {8'h00, s.cfg.chg_ot_delay, s.cfg.chg_ot_recov, s.cfg.chg_ot_limit};
      `OFS_DSG_OT:   v = {8'h00, s.cfg.dsg_ot_delay, s.cfg.dsg_ot_recov, s.cfg.dsg_ot_limit};
      `OFS_INHIBIT:  v = {8'h00, s.cfg.inh_hys, s.cfg.inh_high, s.cfg.inh_low};
      `OFS_SUSPEND:  v = {8'h00, s.cfg.sus_delta, s.cfg.sus_high, s.cfg.sus_low};
      `OFS_CURRENT:  v = {s.cfg.dsg_cur, s.cfg.chg_cur};
      `OFS_CHG_VOLT: v = {16'h0000, s.cfg.chg_volt};
      `OFS_TEMP:     v = {s.chg_timer, s.dsg_timer, 8'h00, s.last_temp};
      default:       ok = 1'b0;
    endcase
    return {ok, v};
  endfunction

  logic signed [8:0] t9;
  logic              chg_now;
  logic              dsg_now;
  logic [8:0]        ct;
  logic [8:0]        dt;
  logic [32:0]       rd;
  logic [31:0]       wv;
  logic              w_ok;

  always_comb begin
    d       = q;
    t9      = 9'(sample.temp);
    chg_now = sample.current > q.cfg.chg_cur;
    dsg_now = sample.current < -q.cfg.dsg_cur;
    ct      = 9'h000;
    dt      = 9'h000;
    rd      = 33'h0;
    wv      = 32'h0;
    w_ok    = 1'b1;

    // Flags and timers move only on a fresh sample.
    if (sample.valid) begin
      d.charging    = chg_now;
      d.discharging = dsg_now;
      d.last_temp   = sample.temp;

      // Timer counts while condition holds and resets when it drops.
      ct = timer_step(chg_now && sample.temp >= q.cfg.chg_ot_limit,
                      q.chg_timer, q.cfg.chg_ot_delay);
      d.chg_timer = ct[7:0];
      if (ct[8]) begin
        d.flags.chg_ot = 1'b1;
      end else if (sample.temp <= q.cfg.chg_ot_recov) begin
        d.flags.chg_ot = 1'b0;
      end

      dt = timer_step(dsg_now && sample.temp >= q.cfg.dsg_ot_limit,
                      q.dsg_timer, q.cfg.dsg_ot_delay);
      d.dsg_timer = dt[7:0];
      if (dt[8]) begin
        d.flags.dsg_ot = 1'b1;
      end else if (sample.temp <= q.cfg.dsg_ot_recov) begin
        d.flags.dsg_ot = 1'b0;
      end

      if (chg_now && (sample.temp <= q.cfg.inh_low || sample.temp >= q.cfg.inh_high)) begin
        d.flags.inhibit = 1'b1;
      end else if (t9 >= 9'(q.cfg.inh_low) + 9'(q.cfg.inh_hys) &&
                   t9 <= 9'(q.cfg.inh_high) - 9'(q.cfg.inh_hys)) begin
        d.flags.inhibit = 1'b0;
      end

      if (chg_now && (sample.temp <= q.cfg.sus_low || sample.temp >= q.cfg.sus_high)) begin
        d.flags.suspend = 1'b1;
      end else if (t9 >= 9'(q.cfg.sus_low) + 9'(q.cfg.sus_delta) &&
                   t9 <= 9'(q.cfg.sus_high) - 9'(q.cfg.sus_delta)) begin
        d.flags.suspend = 1'b0;
      end
    end

    // Termination level is charge voltage less the taper offset.
    d.term_level = q.cfg.chg_volt - q.cfg.taper_volt;

    // Write channel: address and data are taken in either order.
    d.awready = 1'b0;
    d.wready  = 1'b0;
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    case (q.wr_state)
      temp_flag_pkg::WR_IDLE: begin
        if (q.aw_held && q.w_held) begin
          rd   = read_reg(q, q.aw_addr);
          wv   = merge(rd[31:0], q.w_data, q.w_strb);
          w_ok = rd[32];
          case (q.aw_addr)
            `OFS_CTRL:     d.cfg.taper_volt = wv[15:0];
            `OFS_CHG_OT:   {d.cfg.chg_ot_delay, d.cfg.chg_ot_recov, d.cfg.chg_ot_limit}
                             = wv[23:0];
            `OFS_DSG_OT:   {d.cfg.dsg_ot_delay, d.cfg.dsg_ot_recov, d.cfg.dsg_ot_limit}
                             = wv[23:0];
            `OFS_INHIBIT:  {d.cfg.inh_hys, d.cfg.inh_high, d.cfg.inh_low} = wv[23:0];
            `OFS_SUSPEND:  {d.cfg.sus_delta, d.cfg.sus_high, d.cfg.sus_low} = wv[23:0];
            `OFS_CURRENT:  {d.cfg.dsg_cur, d.cfg.chg_cur} = wv;
            `OFS_CHG_VOLT: d.cfg.chg_volt = wv[15:0];
            default:       w_ok = rd[32];
          endcase
          d.aw_held  = 1'b0;
          d.w_held   = 1'b0;
          d.bvalid   = 1'b1;
          d.bresp    = w_ok ? 2'h0 : 2'h2;
          d.wr_state = temp_flag_pkg::WR_RESP;
        end else begin
          d.awready = !d.aw_held && !(s_axi_awvalid && q.awready);
          d.wready  = !d.w_held && !(s_axi_wvalid && q.wready);
        end
      end
      temp_flag_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          d.bvalid   = 1'b0;
          d.wr_state = temp_flag_pkg::WR_IDLE;
        end
      end
      default: d.wr_state = temp_flag_pkg::WR_IDLE;
    endcase

    // Read channel: one read at a time, answered the cycle after acceptance.
    d.arready = 1'b0;
    if (q.rvalid) begin
      if (s_axi_rready) begin
        d.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid && q.arready) begin
      rd       = read_reg(q, s_axi_araddr);
      d.rvalid = 1'b1;
      d.rdata  = rd[31:0];
      d.rresp  = rd[32] ? 2'h0 : 2'h2;
    end else begin
      d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q                  <= '0;
      q.cfg.chg_ot_limit <= `RST_CHG_OT_LIMIT;
      q.cfg.chg_ot_recov <= `RST_CHG_OT_RECOV;
      q.cfg.chg_ot_delay <= `RST_DELAY;
      q.cfg.dsg_ot_limit <= `RST_DSG_OT_LIMIT;
      q.cfg.dsg_ot_recov <= `RST_DSG_OT_RECOV;
      q.cfg.dsg_ot_delay <= `RST_DELAY;
      q.cfg.inh_low      <= `RST_INH_LOW;
      q.cfg.inh_high     <= `RST_INH_HIGH;
      q.cfg.inh_hys      <= `RST_INH_HYS;
      q.cfg.sus_low      <= `RST_SUS_LOW;
      q.cfg.sus_high     <= `RST_SUS_HIGH;
      q.cfg.sus_delta    <= `RST_SUS_DELTA;
      q.cfg.chg_cur      <= `RST_CHG_CUR;
      q.cfg.dsg_cur      <= `RST_DSG_CUR;
      q.cfg.chg_volt     <= `RST_CHG_VOLT;
      q.cfg.taper_volt   <= `RST_TAPER_VOLT;
      q.term_level       <= `RST_CHG_VOLT - `RST_TAPER_VOLT;
      q.wr_state         <= temp_flag_pkg::WR_IDLE;
    end else begin
      q <= d;
    end
  end

  assign term_voltage_level      = q.term_level;
  assign charge_overtemp_flag    = q.flags.chg_ot;
  assign discharge_overtemp_flag = q.flags.dsg_ot;
  assign charge_inhibit_flag     = q.flags.inhibit;
  assign charge_suspend_flag     = q.flags.suspend;
  assign s_axi_awready           = q.awready;
  assign s_axi_wready            = q.wready;
  assign s_axi_bvalid            = q.bvalid;
  assign s_axi_bresp             = q.bresp;
  assign s_axi_arready           = q.arready;
  assign s_axi_rvalid            = q.rvalid;
  assign s_axi_rdata             = q.rdata;
  assign s_axi_rresp             = q.rresp;

endmodule

// >>> rtl/temp_flag_params.svh
// Offsets, field positions, reset values and timing counts of the temperature flag monitor.
`ifndef TEMP_FLAG_PARAMS_SVH
`define TEMP_FLAG_PARAMS_SVH

// Register byte offsets.
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_CHG_OT      12'h008
`define OFS_DSG_OT      12'h00c
`define OFS_INHIBIT     12'h010
`define OFS_SUSPEND     12'h014
`define OFS_CURRENT     12'h018
`define OFS_CHG_VOLT    12'h01c
`define OFS_TEMP        12'h020

// Status bit positions.
`define ST_CHG_OT       0
`define ST_DSG_OT       1
`define ST_INHIBIT      2
`define ST_SUSPEND      3
`define ST_CHARGING     4
`define ST_DISCHARGING  5

// Reset values; temperatures in signed whole degrees C, delays in samples.
`define RST_CHG_OT_LIMIT  8'sd55
`define RST_CHG_OT_RECOV  8'sd50
`define RST_DSG_OT_LIMIT  8'sd60
`define RST_DSG_OT_RECOV  8'sd55
`define RST_INH_LOW       8'sd0
`define RST_INH_HIGH      8'sd45
`define RST_INH_HYS       8'sd5
`define RST_SUS_LOW       (-8'sd5)
`define RST_SUS_HIGH      8'sd55
`define RST_SUS_DELTA     8'sd5
`define RST_DELAY         8'h02
`define RST_CHG_CUR       16'sd50
`define RST_DSG_CUR       16'sd60
`define RST_CHG_VOLT      16'd4200
`define RST_TAPER_VOLT    16'd100

`endif

// >>> rtl/temp_flag_pkg.sv
// Types shared by the temperature flag monitor.
package temp_flag_pkg;

  typedef struct packed {
    logic              valid;
    logic signed [7:0] temp;
    logic signed [15:0] current;
  } sample_s;

  typedef struct packed {
    logic       chg_ot;
    logic       dsg_ot;
    logic       inhibit;
    logic       suspend;
  } flags_s;

  typedef struct packed {
    logic signed [7:0]  chg_ot_limit;
    logic signed [7:0]  chg_ot_recov;
    logic [7:0]         chg_ot_delay;
    logic signed [7:0]  dsg_ot_limit;
    logic signed [7:0]  dsg_ot_recov;
    logic [7:0]         dsg_ot_delay;
    logic signed [7:0]  inh_low;
    logic signed [7:0]  inh_high;
    logic signed [7:0]  inh_hys;
    logic signed [7:0]  sus_low;
    logic signed [7:0]  sus_high;
    logic signed [7:0]  sus_delta;
    logic signed [15:0] chg_cur;
    logic signed [15:0] dsg_cur;
    logic [15:0]        chg_volt;
    logic [15:0]        taper_volt;
  } cfg_s;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_e;

  typedef struct packed {
    cfg_s              cfg;
    flags_s            flags;
    logic [7:0]        chg_timer;
    logic [7:0]        dsg_timer;
    logic              charging;
    logic              discharging;
    logic signed [7:0] last_temp;
    logic [15:0]       term_level;
    wr_state_e         wr_state;
    logic              aw_held;
    logic [11:0]       aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_s;

endpackage

// >>> verif/meas_front_end.sv
// Behavioural model of the temperature and current measurement front end.
`timescale 1ns/1ps
module meas_front_end (
  // Clock.
  input wire logic               aclk,
  // Sample stream towards the monitor.
  output temp_flag_pkg::sample_s sample
);
  initial sample = '0;
  // One-cycle sample, then scrambled data lines and a gap of idle cycles.
  task automatic send(input logic signed [7:0] t, input logic signed [15:0] c, input int gap);
    @(posedge aclk);
    sample <= '{1'b1, t, c};
    @(posedge aclk);
    sample <= '{1'b0, ~t, ~c};
    repeat (gap) @(posedge aclk);
  endtask
endmodule

// >>> verif/tb.sv
// Self-checking bench for the temperature flag monitor.
`timescale 1ns/1ps
`include "temp_flag_params.svh"
module tb;
  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  temp_flag_pkg::sample_s sample;
  logic                   charge_overtemp_flag, discharge_overtemp_flag;
  logic                   charge_inhibit_flag, charge_suspend_flag;
  logic [15:0]            term_voltage_level;
  logic [11:0]            s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]             s_axi_wstrb = 4'hf;
  logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]             s_axi_bresp, s_axi_rresp, r;
  int                     fails = 0, n_checks = 0, cyc = 0;
  wire [3:0]              flags = {charge_overtemp_flag, discharge_overtemp_flag,
                                   charge_inhibit_flag, charge_suspend_flag};
  // Sample temperatures; high nibble of ef is the current kind, low nibble the flags.
  logic signed [7:0]      temps [17] = '{8'sh19, 8'sh37, 8'sh19, 8'sh37, 8'sh38, 8'sh33,
    8'sh32, 8'sh28, 8'sh3c, 8'sh1e, 8'sh3c, 8'sh3d, 8'sh38, 8'sh37, 8'sh00, -8'sh05, 8'sh05};
  logic [7:0]             ef [17] = '{8'h10, 8'h13, 8'h10, 8'h13, 8'h1b, 8'h0b, 8'h02, 8'h00,
    8'h20, 8'h20, 8'h20, 8'h24, 8'h04, 8'h00, 8'h12, 8'h13, 8'h10};

  always #5 aclk = ~aclk;

  meas_front_end fe (.aclk, .sample);
  temp_flag_monitor uut (.aclk, .aresetn, .sample, .charge_overtemp_flag,
    .discharge_overtemp_flag, .charge_inhibit_flag, .charge_suspend_flag, .term_voltage_level,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  function automatic logic signed [15:0] cur_of(input logic [3:0] k);
    return k == 4'h1 ? 16'sh0064 : (k == 4'h2 ? -16'sh0064 : 16'sh0000);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(flags, 4'h0, "flags after reset");
    chk(term_voltage_level, `RST_CHG_VOLT - `RST_TAPER_VOLT, "termination level");
    $display("test reset done");
    for (int i = 0; i < 17; i++) begin
      fe.send(temps[i], cur_of(ef[i][7:4]), i % 3);
      @(negedge aclk);
      chk(flags, ef[i][3:0], "row flags");
    end
    $display("test rows done");
    rd(12'h01c, d, r);
    chk({d, r}, {16'h0, `RST_CHG_VOLT, 2'b00}, "charge voltage");
    rd(12'h008, d, r);
    chk(d, {8'h00, `RST_DELAY, `RST_CHG_OT_RECOV, `RST_CHG_OT_LIMIT}, "charge limits");
    rd(12'h100, d, r);
    chk(r, 2'b10, "unmapped read");
    wr(12'h104, 32'h1, r);
    chk(r, 2'b10, "unmapped write");
    wr(12'h000, 32'h000000c8, r);
    @(negedge aclk);
    chk(term_voltage_level, `RST_CHG_VOLT - 16'h00c8, "taper offset");
    $display("test registers done");
    wr(12'h008, {16'h0, `RST_CHG_OT_RECOV, `RST_CHG_OT_LIMIT}, r);
    wr(12'h00c, {16'h0, `RST_DSG_OT_RECOV, `RST_DSG_OT_LIMIT}, r);
    repeat (3) fe.send(8'sh3c, 16'sh0064, 1);
    repeat (3) fe.send(8'sh46, -16'sh0064, 0);
    @(negedge aclk);
    chk(flags[3:2], 2'b00, "zero delay disables");
    $display("test zero delay done");
    rd(12'h004, d, r);
    chk(d, 1 << `ST_DISCHARGING | 1 << `ST_INHIBIT | 1 << `ST_SUSPEND, "status");
    rd(12'h020, d, r);
    chk(d, {24'h0, 8'sh46}, "timers idle at zero delay");
    $display("test status done");
    s_axi_wstrb <= 4'h1;
    wr(12'h01c, 32'hffff_ffff, r);
    s_axi_wstrb <= 4'hf;
    rd(12'h01c, d, r);
    chk(d, {16'h0, `RST_CHG_VOLT | 16'h00ff}, "byte strobe merge");
    @(negedge aclk);
    chk(term_voltage_level, (`RST_CHG_VOLT | 16'h00ff) - 16'h00c8, "merged level");
    $display("test strobe done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(flags, 4'h0, "flags after mid-run reset");
    chk(term_voltage_level, `RST_CHG_VOLT - `RST_TAPER_VOLT, "level restored");
    rd(12'h008, d, r);
    chk(d, {8'h00, `RST_DELAY, `RST_CHG_OT_RECOV, `RST_CHG_OT_LIMIT}, "defaults back");
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule

// >>> verif/temp_flag_properties.sv
// Assertions on the flag outputs of the temperature flag monitor.
`timescale 1ns/1ps
`include "temp_flag_params.svh"
module temp_flag_checker (
  // Clock and reset.
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // Samples and flags.
  input wire temp_flag_pkg::sample_s sample,
  input wire logic                   charge_overtemp_flag,
  input wire logic                   discharge_overtemp_flag,
  input wire logic                   charge_inhibit_flag,
  input wire logic                   charge_suspend_flag
);
  wire              chg = sample.valid && sample.current > `RST_CHG_CUR;
  wire              dsg = sample.valid && sample.current < -`RST_DSG_CUR;
  wire signed [7:0] t   = sample.temp;
  wire [3:0]        fl  = {charge_overtemp_flag, discharge_overtemp_flag,
                           charge_inhibit_flag, charge_suspend_flag};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  flags_hold_a: assert property (!sample.valid |=> $stable(fl))
    else $error("flags moved without a sample");
  chg_ot_set_a: assert property (
    $rose(charge_overtemp_flag) |-> $past(chg && t >= `RST_CHG_OT_LIMIT))
    else $error("charge overtemp set without hot charging sample");
  chg_ot_clear_a: assert property (
    $fell(charge_overtemp_flag) |-> $past(sample.valid && t <= `RST_CHG_OT_RECOV))
    else $error("charge overtemp cleared above recovery");
  dsg_ot_set_a: assert property (
    $rose(discharge_overtemp_flag) |-> $past(dsg && t >= `RST_DSG_OT_LIMIT))
    else $error("discharge overtemp set without hot discharging sample");
  dsg_ot_clear_a: assert property (
    $fell(discharge_overtemp_flag) |-> $past(sample.valid && t <= `RST_DSG_OT_RECOV))
    else $error("discharge overtemp cleared above recovery");
  inhibit_high_a: assert property (
    chg && t >= `RST_INH_HIGH |=> charge_inhibit_flag)
    else $error("inhibit missing at high temperature");
  inhibit_clear_a: assert property (
    $fell(charge_inhibit_flag) |-> $past(sample.valid && t >= `RST_INH_LOW + `RST_INH_HYS
      && t <= `RST_INH_HIGH - `RST_INH_HYS))
    else $error("inhibit cleared outside band");
  suspend_set_a: assert property (
    $rose(charge_suspend_flag) |-> $past(chg && (t <= `RST_SUS_LOW || t >= `RST_SUS_HIGH)))
    else $error("suspend set inside range");
  suspend_low_a: assert property (chg && t <= `RST_SUS_LOW |=> charge_suspend_flag)
    else $error("suspend missing at low temperature");
  suspend_clear_a: assert property (
    $fell(charge_suspend_flag) |-> $past(sample.valid && t >= `RST_SUS_LOW + `RST_SUS_DELTA
      && t <= `RST_SUS_HIGH - `RST_SUS_DELTA))
    else $error("suspend cleared outside band");
  chg_ot_cov: cover property ($rose(charge_overtemp_flag));
  dsg_ot_cov: cover property ($rose(discharge_overtemp_flag));
  suspend_cov: cover property ($fell(charge_suspend_flag));
endmodule
bind temp_flag_monitor temp_flag_checker chk_i (.aclk, .aresetn, .sample, .charge_overtemp_flag,
  .discharge_overtemp_flag, .charge_inhibit_flag, .charge_suspend_flag);
